// ---- srl_pkg.sv ----
// Package: register map, field positions, reset values and divider codes
package srl_pkg;
	localparam logic [0:0] ADDR_CONTROL = 1'h0;
	localparam logic [0:0] ADDR_SOURCE = 1'h1;
	localparam int CTL_ENABLE_BIT = 7;
	localparam int CTL_DIV_LSB = 4;
	localparam int CTL_TRUE_OE_BIT = 3;
	localparam int CTL_INV_OE_BIT = 2;
	localparam int CTL_SET_PULSE_BIT = 1;
	localparam int CTL_RESET_PULSE_BIT = 0;
	localparam int SRC_PERIPH_SET_BIT = 7;
	localparam int SRC_CLOCK_SET_BIT = 6;
	localparam int SRC_CMP2_SET_BIT = 5;
	localparam int SRC_CMP1_SET_BIT = 4;
	localparam int SRC_PERIPH_RST_BIT = 3;
	localparam int SRC_CLOCK_RST_BIT = 2;
	localparam int SRC_CMP2_RST_BIT = 1;
	localparam int SRC_CMP1_RST_BIT = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] SOURCE_RESET = 8'h00;
	localparam int DIV_MIN_LOG2 = 2;
	localparam int DIV_CTR_WIDTH = 9;
endpackage : srl_pkg

// ---- srl_divider.sv ----
// Pulse clock divider: one-cycle enable every 4..512 peripheral cycles
`timescale 1ns/1ps
`default_nettype none
module srl_divider #(
	parameter int CTR_WIDTH = srl_pkg::DIV_CTR_WIDTH
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [2:0] div_sel,
	output logic pulse
);
	logic [CTR_WIDTH-1:0] count_r;
	logic [CTR_WIDTH-1:0] mask;

	// Code n divides by 2^(n+2)
	assign mask = CTR_WIDTH'((1 << (32'(div_sel) + srl_pkg::DIV_MIN_LOG2)) - 1);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			count_r <= '0;
		// Holds between peripheral cycles so a slow enable stretches the period
		else if (run)
			count_r <= count_r + 1'b1;
	end

	// R9
	assign pulse = run && ((count_r & mask) == mask);

	chk_pulse_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(pulse && div_sel == 3'h0 && $stable(div_sel)) |=> !pulse [*3]) // R9
		else $error("divide-by-4 pulse repeated early");
endmodule : srl_divider
`default_nettype wire

// ---- srl_latch_control.sv ----
// Set/reset latch control: registers, source gating and latch state
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Control bit 7 enables the latch when one, disables when zero.
// R2 - Comparator-2 set enable lets comparator 2 output set the latch.
// R3 - Comparator-1 set enable lets comparator 1 output set the latch.
// R4 - Peripheral set enable lets the peripheral input set the latch.
// R5 - Set and reset high together leave the latch reset.
// R6 - Firmware set and reset pulse bits self clear and read zero.
// R7 - Sources are comparators, interrupt pin and divided clock, each separately enabled.
// R8 - Latch state is undefined after reset; firmware initialises before enabling pins.
// R9 - Divider codes 000..111 give peripheral clock over 4 up to 512.
module srl_latch_control (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [0:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic peripheral_cycle_enable,
	input wire logic [1:0] comparator_output,
	input wire logic external_interrupt_pin_one,
	output logic latch_q,
	output logic latch_q_n,
	output logic true_output_pin_enable,
	output logic inverted_output_pin_enable,
	output logic true_output_pin,
	output logic inverted_output_pin
);
	logic rst_meta_r;
	logic rst_sync_r;
	logic [7:0] control_r;
	logic [7:0] source_r;
	logic set_pulse_r;
	logic reset_pulse_r;
	logic state_r;
	logic state_nxt;
	logic clock_pulse;
	logic clock_tick_r;
	logic set_in;
	logic reset_in;
	logic latch_enable;
	logic divider_run;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// Control register; pulse bits never stored
	always_ff @(posedge ref_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
			control_r <= srl_pkg::CONTROL_RESET;
		else if (reg_write && reg_addr == srl_pkg::ADDR_CONTROL)
			control_r <= reg_wdata & 8'hfc; // R6
	end

	always_ff @(posedge ref_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
			source_r <= srl_pkg::SOURCE_RESET;
		else if (reg_write && reg_addr == srl_pkg::ADDR_SOURCE)
			source_r <= reg_wdata;
	end

	// One-cycle firmware pulses
	always_ff @(posedge ref_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
		begin
			set_pulse_r <= 1'b0;
			reset_pulse_r <= 1'b0;
		end
		else
		begin
			set_pulse_r <= reg_write && reg_addr == srl_pkg::ADDR_CONTROL
				&& reg_wdata[srl_pkg::CTL_SET_PULSE_BIT]; // R6
			reset_pulse_r <= reg_write && reg_addr == srl_pkg::ADDR_CONTROL
				&& reg_wdata[srl_pkg::CTL_RESET_PULSE_BIT]; // R6
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
			reg_rdata <= 8'h00;
		else if (reg_read)
			reg_rdata <= (reg_addr == srl_pkg::ADDR_CONTROL) ? control_r : source_r;
		else
			reg_rdata <= 8'h00;
	end

	assign latch_enable = control_r[srl_pkg::CTL_ENABLE_BIT]; // R1

	assign divider_run = latch_enable && peripheral_cycle_enable;

	srl_divider u_div (
		.ref_clk(ref_clk),
		.rst_n(rst_sync_r),
		.run(divider_run),
		.div_sel(control_r[srl_pkg::CTL_DIV_LSB +: 3]),
		.pulse(clock_pulse)
	);

	// Divider ticks in peripheral cycles; hold level one cycle as a clock source
	always_ff @(posedge ref_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
			clock_tick_r <= 1'b0;
		else
			clock_tick_r <= clock_pulse;
	end

	// R7
	assign set_in = set_pulse_r
		| (source_r[srl_pkg::SRC_PERIPH_SET_BIT] & external_interrupt_pin_one) // R4
		| (source_r[srl_pkg::SRC_CLOCK_SET_BIT] & clock_tick_r)
		| (source_r[srl_pkg::SRC_CMP2_SET_BIT] & comparator_output[1]) // R2
		| (source_r[srl_pkg::SRC_CMP1_SET_BIT] & comparator_output[0]); // R3
	assign reset_in = reset_pulse_r
		| (source_r[srl_pkg::SRC_PERIPH_RST_BIT] & external_interrupt_pin_one)
		| (source_r[srl_pkg::SRC_CLOCK_RST_BIT] & clock_tick_r)
		| (source_r[srl_pkg::SRC_CMP2_RST_BIT] & comparator_output[1])
		| (source_r[srl_pkg::SRC_CMP1_RST_BIT] & comparator_output[0]);

	always_comb
	begin
		state_nxt = state_r;
		if (!latch_enable)
			state_nxt = state_r; // R1
		else if (reset_in)
			state_nxt = 1'b0; // R5
		else if (set_in)
			state_nxt = 1'b1;
	end

	// Real latch state is undefined at reset; zero keeps simulation clean (R8)
	always_ff @(posedge ref_clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
			state_r <= 1'b0;
		else
			state_r <= state_nxt;
	end

	assign latch_q = state_r;
	assign latch_q_n = ~state_r;
	assign true_output_pin_enable = latch_enable && control_r[srl_pkg::CTL_TRUE_OE_BIT];
	assign inverted_output_pin_enable = latch_enable && control_r[srl_pkg::CTL_INV_OE_BIT];
	assign true_output_pin = state_r;
	assign inverted_output_pin = ~state_r;

	chk_reset_dominant: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		(latch_enable && reset_in) |=> !latch_q) // R5
		else $error("reset did not win");
	chk_set_works: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		(latch_enable && set_in && !reset_in) |=> latch_q) // R7
		else $error("set ignored");
	chk_disabled_hold: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		!latch_enable |=> $stable(latch_q)) // R1
		else $error("disabled latch moved");
	chk_cmp2_set: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		(latch_enable && source_r[5] && comparator_output[1] && !reset_in) |=> latch_q) // R2
		else $error("comparator 2 set missed");
	chk_cmp1_set: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		(latch_enable && source_r[4] && comparator_output[0] && !reset_in) |=> latch_q) // R3
		else $error("comparator 1 set missed");
	chk_periph_set: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		(latch_enable && source_r[7] && external_interrupt_pin_one && !reset_in)
		|=> latch_q) // R4
		else $error("peripheral set missed");
	chk_pulse_self: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		set_pulse_r |=> !set_pulse_r || $past(reg_write)) // R6
		else $error("set pulse stuck");
	chk_read_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		(reg_read && reg_addr == srl_pkg::ADDR_CONTROL) |=> reg_rdata[1:0] == 2'h0) // R6
		else $error("pulse bits read nonzero");
	chk_clock_set: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		(latch_enable && source_r[srl_pkg::SRC_CLOCK_SET_BIT] && clock_tick_r && !reset_in)
		|=> latch_q) // R7
		else $error("clock set missed");
	chk_periph_reset: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		(latch_enable && source_r[srl_pkg::SRC_PERIPH_RST_BIT] && external_interrupt_pin_one)
		|=> !latch_q) // R7
		else $error("peripheral reset missed");
	chk_clock_reset: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		(latch_enable && source_r[srl_pkg::SRC_CLOCK_RST_BIT] && clock_tick_r)
		|=> !latch_q) // R7
		else $error("clock reset missed");
	chk_cmp2_reset: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		(latch_enable && source_r[srl_pkg::SRC_CMP2_RST_BIT] && comparator_output[1])
		|=> !latch_q) // R7
		else $error("comparator 2 reset missed");
	chk_cmp1_reset: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		(latch_enable && source_r[srl_pkg::SRC_CMP1_RST_BIT] && comparator_output[0])
		|=> !latch_q) // R7
		else $error("comparator 1 reset missed");
	chk_quiet_hold: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		(latch_enable && !set_in && !reset_in) |=> $stable(latch_q)) // R7
		else $error("latch moved with no source");
	chk_tick_single: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		clock_tick_r |=> !clock_tick_r) // R9
		else $error("clock tick longer than one cycle");

	// Firmware pulse: write, then one pulse cycle, then the latch follows
	sequence seq_fw_set;
		reg_write && reg_addr == srl_pkg::ADDR_CONTROL && reg_wdata[srl_pkg::CTL_ENABLE_BIT]
			&& reg_wdata[srl_pkg::CTL_SET_PULSE_BIT];
	endsequence
	sequence seq_fw_reset;
		reg_write && reg_addr == srl_pkg::ADDR_CONTROL && reg_wdata[srl_pkg::CTL_ENABLE_BIT]
			&& reg_wdata[srl_pkg::CTL_RESET_PULSE_BIT];
	endsequence
	chk_fw_set: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		seq_fw_set ##1 !reset_in |=> latch_q) // R6
		else $error("firmware set missed");
	chk_fw_reset: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
		seq_fw_reset |-> ##2 !latch_q) // R6
		else $error("firmware reset missed");
endmodule : srl_latch_control
`default_nettype wire

// ---- srl_latch_control_tb.sv ----
// Self-checking bench for the set/reset latch control block
`timescale 1ns/1ps
`default_nettype none
module srl_latch_control_tb;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [0:0] reg_addr = 1'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	logic [1:0] comparator_output = 2'h0;
	logic external_interrupt_pin_one = 1'b0;
	logic latch_q, latch_q_n, true_output_pin_enable, inverted_output_pin_enable;
	logic true_output_pin, inverted_output_pin;
	int err_total = 0;
	int cmp_count = 0;
	int cnt;
	int expv;
	logic periph_en = 1'b1;
	logic [2:0] pin_tab [4] = '{3'h4, 3'h0, 3'h2, 3'h1};
	srl_latch_control u_srl_latch_control (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_rdata(reg_rdata),
		.peripheral_cycle_enable(periph_en),
		.comparator_output(comparator_output),
		.external_interrupt_pin_one(external_interrupt_pin_one),
		.latch_q(latch_q),
		.latch_q_n(latch_q_n),
		.true_output_pin_enable(true_output_pin_enable),
		.inverted_output_pin_enable(inverted_output_pin_enable),
		.true_output_pin(true_output_pin),
		.inverted_output_pin(inverted_output_pin)
	);
	initial
	begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [0:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [0:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1 chk({8'h00, reg_rdata}, {8'h00, exp});
	endtask : rd
	// Latch and its inverse after sources settle
	task automatic q(input logic e);
		repeat (8) @(posedge ref_clk);
		#1 chk({14'h0, latch_q, latch_q_n}, {14'h0, e, ~e});
	endtask : q
	task automatic pins(input logic [2:0] v);
		@(posedge ref_clk);
		{external_interrupt_pin_one, comparator_output} <= v;
	endtask : pins
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	initial
	begin
		#1000000;
		err_total++;
		close_out();
	end
	initial
	begin
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(1'h0, 8'h00);
		rd(1'h1, 8'h00);
		wr(1'h0, 8'h82);
		q(1'b1);
		rd(1'h0, 8'h80);
		wr(1'h0, 8'h81);
		q(1'b0);
		// Set side starts low, reset side high; a zero enable must leave the latch alone
		for (int k = 0; k < 8; k++)
		begin
			wr(1'h0, (k < 4) ? 8'h81 : 8'h82);
			pins(pin_tab[k % 4]);
			q(k >= 4);
			wr(1'h1, 8'h80 >> k);
			q(k < 4);
			wr(1'h1, 8'h00);
			pins(3'h0);
		end
		wr(1'h1, 8'h00);
		pins(3'h7);
		q(1'b0);
		wr(1'h0, 8'h00);
		wr(1'h1, 8'h10);
		q(1'b0);
		wr(1'h0, 8'h80);
		q(1'b1);
		wr(1'h1, 8'h11);
		q(1'b0);
		// Latch is known low before any pin output is enabled
		wr(1'h0, 8'h88);
		#1 chk({12'h0, true_output_pin_enable, inverted_output_pin_enable, true_output_pin,
			inverted_output_pin}, 16'h0009);
		wr(1'h0, 8'h84);
		rd(1'h0, 8'h84);
		chk({14'h0, true_output_pin_enable, inverted_output_pin_enable}, 16'h0001);
		// Each divided tick wins over the held set for one cycle; last pass halves the rate
		wr(1'h1, 8'h14);
		for (int c = 0; c < 9; c++)
		begin
			wr(1'h0, {1'b1, c[2:0], 4'h0});
			cnt = 0;
			expv = (c == 8) ? 256 : 2048 >> (c + 2);
			for (int n = 0; n < 2064; n++)
			begin
				@(posedge ref_clk);
				if (c == 8)
					periph_en <= ~periph_en;
				#1 cnt += (n >= 16 && latch_q === 1'b0) ? 1 : 0;
			end
			chk(cnt[15:0], expv[15:0]);
		end
		close_out();
	end
endmodule : srl_latch_control_tb
`default_nettype wire
